// ---- hdl/iotf_pkg.sv ----
package iotf_pkg;

  // Register offsets within one page
  localparam logic [11:0] OFS_CAP0 = 12'h000;
  localparam logic [11:0] OFS_CAP1 = 12'h004;
  localparam logic [11:0] OFS_CAP2 = 12'h008;
  localparam logic [11:0] OFS_UNIT_CONTROL = 12'h010;
  localparam logic [11:0] OFS_TLB_FLUSH = 12'h014;
  localparam logic [11:0] OFS_UNIT_STATUS = 12'h018;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h01C;
  localparam logic [11:0] OFS_DENIED_ADDR = 12'h020;
  localparam logic [11:0] OFS_MASTER_BASE = 12'h040;
  localparam logic [11:0] OFS_GROUP_BASE = 12'h080;
  localparam logic [11:0] OFS_DIAG_ACCESS = 12'h0C0;
  localparam logic [11:0] OFS_DIAG_DATA = 12'h0C4;
  localparam logic [11:0] OFS_DIAG_TAG = 12'h0E4;
  localparam logic [11:0] OFS_DATA_INJECT = 12'h0E8;
  localparam logic [11:0] OFS_TAG_INJECT = 12'h0EC;
  localparam logic [11:0] OFS_GUARD_BASE = 12'h100;
  localparam int PAGE_SHIFT = 12;
  localparam int MIRROR_PAGES = 4;

  // Control register field positions
  localparam int CTL_SAVE_INVALID = 10;
  localparam int CTL_GROUP_SET = 4;

  // Flush register fields: bit 0 flush all, bit 1 group flush, group in 6:4
  localparam int FL_ALL = 0;
  localparam int FL_GROUP = 1;
  localparam int FL_GID_LO = 4;

  // Status register: parity error sticky bit
  localparam int ST_PARITY = 8;

  // Guard register field positions: which writable register kinds a page may write
  localparam int GD_FLUSH = 0;
  localparam int GD_STATUS = 1;
  localparam int GD_MASK = 2;
  localparam int GD_GROUP_LO = 16;

  // Capability word 0 to 2 read constants
  localparam logic [31:0] CAP0_VALUE = 32'hE04B_E178;
  localparam logic [31:0] CAP1_VALUE = 32'h0001_0B45;
  localparam logic [31:0] CAP2_VALUE = 32'hFF00_1045;

  // TLB geometry
  localparam int TLB_ENTRIES = 32;
  localparam int SET_BITS = 5;
  localparam int GROUP_BITS = 3;
  localparam int TAG_BITS = 17;
  localparam int TAG_VALID = 0;
  localparam int LINE_BITS = 128;

  // Lookup request carried as one group
  typedef struct packed {
    logic [31:0] addr;
    logic [GROUP_BITS-1:0] gid;
  } iotf_req_t;

  // Table walk answer
  typedef struct packed {
    logic [LINE_BITS-1:0] line;
    logic pte_valid;
  } iotf_fill_t;

  // Statistics pulses and levels
  typedef struct packed {
    logic hit;
    logic miss;
    logic pass;
    logic acc_ok;
    logic acc_err;
    logic walk;
    logic lookup;
    logic perr;
  } iotf_stat_t;

endpackage : iotf_pkg

// ---- hdl/iotf_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Tag bit zero marks entry valid
// - Group-set: group low, address high index
// - Control bit enables group-set addressing
// - Otherwise index purely from address bits
// - Flush write in idle clears all, or sets whose low index bits equal the group
// - Invalid entries not stored unless enabled
// - No forwarding while flush runs
// - Byte parity stored, checked each read
// - Parity error treated as miss
// - Parity error recorded and signalled
// - Two registers inject RAM faults
// - Event statistics pulse one cycle
// - Walk and lookup held while busy
// - Parity statistics pulse one cycle
// - Four mirrored pages, each guarded
// - Mirrors never write primary-only registers
// - Mirror writes gated by page guard
// - Master and group register arrays
// - Capability word reads fixed constants
// - Direct-mapped 32 entries, 16 bytes
// - Five-bit set index
module iotf_unit import iotf_pkg::*; #(
  parameter int MASTERS = 9,
  parameter int GROUPS = 8
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Register port, word access
  input wire logic reg_sel_in,
  input wire logic reg_write_in,
  input wire logic [14:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_ready_out,
  // Master lookup request
  input wire logic req_valid_in,
  input wire iotf_req_t req_in,
  input wire logic req_bypass_in,
  output logic req_ready_out,
  output logic req_allow_out,
  // Table walk toward main memory
  output logic walk_req_out,
  output logic [31:0] walk_addr_out,
  input wire logic walk_done_in,
  input wire iotf_fill_t walk_fill_in,
  // Forward toward system bus
  output logic fwd_valid_out,
  // Statistics
  output iotf_stat_t stat_out
);

  // Elaboration check on sizes
  initial begin
    if (MASTERS < 1 || MASTERS > 16 || GROUPS < 1 || GROUPS > 8) begin
      $error("iotf_unit: unsupported master or group count");
    end
  end

  // Control machine states:
  // ST_IDLE waits for a flush write or a lookup
  // ST_LOOK compares the stored tag with the request
  // ST_WALK waits for memory to return the line
  // ST_FLUSH clears one set per cycle
  // A flush write wins over a lookup in one cycle
  // Reset enters ST_FLUSH so no stale tag can hit
  // Lookups during a flush are held, not refused
  // Only one lookup is in flight at a time
  typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_WALK, ST_FLUSH} iotf_state_t;

  // Storage:
  // Data lines are 128 bits, one per set
  // Tags are 17 bits, valid flag in bit 0
  // Master, group and guard words in small arrays
  // Diagnostic words are plain storage
  // Guard words change through the primary page only
  // Storage arrays
  logic [LINE_BITS-1:0] data_ram [TLB_ENTRIES];
  logic [LINE_BITS/8-1:0] data_par [TLB_ENTRIES]; // Parity per byte
  logic [TAG_BITS-1:0] tag_ram [TLB_ENTRIES];
  logic [2:0] tag_par [TLB_ENTRIES];
  logic [31:0] master_cfg [MASTERS];
  logic [31:0] group_ctl [GROUPS];
  logic [31:0] guard [MIRROR_PAGES];
  logic [31:0] diag_regs [10];

  // Registers:
  // Each word resets to zero
  // Inject words stay set until cleared
  // Control and status registers
  logic [31:0] unit_control;
  logic [31:0] unit_status;
  logic [31:0] irq_mask;
  logic [31:0] denied_addr;
  logic [31:0] data_inject;
  logic [31:0] tag_inject;
  iotf_state_t state;
  logic [SET_BITS-1:0] flush_idx;
  logic flush_group;
  logic [GROUP_BITS-1:0] flush_gid;
  iotf_req_t cur;
  logic perr_evt;

  // Address layout of the register port:
  // Bits 14:12 select the page, 0 is primary
  // Pages 1 to 4 mirror the primary page
  // Pages above 4 read zero, ignore writes
  // Bits 11:2 select the word
  // Mirror page n uses guard word n-1
  // The primary page has every write right
  // Control, master, diagnostic, inject, guard
  // words are written via the primary page only
  // Flush, status, mask, group words obey the guard
  // Guard bit 16+g opens group word g
  // Register decode
  wire [2:0] page = reg_addr_in[14:12];
  wire [11:0] ofs = {reg_addr_in[11:2], 2'b00};
  wire primary = (page == 3'd0);
  wire page_ok = (page <= 3'(MIRROR_PAGES));
  wire [31:0] pguard = primary ? 32'hFFFF_FFFF : guard[2'(page - 3'd1)];
  wire wr = reg_sel_in & reg_write_in & page_ok;
  wire is_master = (ofs >= OFS_MASTER_BASE) && (ofs < OFS_MASTER_BASE + 12'(4 * MASTERS));
  wire is_group = (ofs >= OFS_GROUP_BASE) && (ofs < OFS_GROUP_BASE + 12'(4 * GROUPS));
  wire is_guard = (ofs >= OFS_GUARD_BASE) && (ofs < OFS_GUARD_BASE + 12'(4 * MIRROR_PAGES));
  wire is_diag = (ofs >= OFS_DIAG_ACCESS) && (ofs <= OFS_DIAG_TAG);
  wire [3:0] widx = ofs[5:2];
  // Primary-only writes
  wire wr_prim = wr & primary;
  // Guarded writes from any page
  wire wr_flush = wr && ofs == OFS_TLB_FLUSH && pguard[GD_FLUSH];
  wire wr_status = wr && ofs == OFS_UNIT_STATUS && pguard[GD_STATUS];
  wire wr_mask = wr && ofs == OFS_IRQ_MASK && pguard[GD_MASK];
  wire wr_group = wr && is_group && pguard[GD_GROUP_LO + 32'(widx[2:0])];

  // Read side:
  // Capability words are fixed constants
  // The flush word shows bit 0 while flushing
  // Reserved offsets and far pages read zero
  // The value is registered toward the port
  // Reads have no side effects
  // Read mux
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (page_ok) begin
      if (ofs == OFS_CAP0) next_rdata = CAP0_VALUE;
      else if (ofs == OFS_CAP1) next_rdata = CAP1_VALUE;
      else if (ofs == OFS_CAP2) next_rdata = CAP2_VALUE;
      else if (ofs == OFS_UNIT_CONTROL) next_rdata = unit_control;
      else if (ofs == OFS_TLB_FLUSH) next_rdata = {31'h0000_0000, state == ST_FLUSH};
      else if (ofs == OFS_UNIT_STATUS) next_rdata = unit_status;
      else if (ofs == OFS_IRQ_MASK) next_rdata = irq_mask;
      else if (ofs == OFS_DENIED_ADDR) next_rdata = denied_addr;
      else if (is_master) next_rdata = master_cfg[widx];
      else if (is_group) next_rdata = group_ctl[widx[2:0]];
      else if (is_diag) next_rdata = diag_regs[4'((ofs - OFS_DIAG_ACCESS) >> 2)];
      else if (ofs == OFS_DATA_INJECT) next_rdata = data_inject;
      else if (ofs == OFS_TAG_INJECT) next_rdata = tag_inject;
      else if (is_guard) next_rdata = guard[widx[1:0]];
    end
  end

  // Set index and tag forming:
  // Group-set mode puts the group in the low
  // three set bits, address 13:12 on top
  // Its tag holds address 29:14 and valid
  // Otherwise address 16:12 form the set
  // and the tag holds group, address 31:19
  // and valid, so groups share sets but never hit each other's entries
  // Toggling the mode without a flush leaves
  // old tags that can still hit when their bits match
  // Set index choice
  wire gs_on = unit_control[CTL_GROUP_SET];
  function automatic logic [SET_BITS-1:0] set_of(input iotf_req_t r, input logic gs);
    set_of = gs ? {r.addr[13:12], r.gid} : r.addr[16:12];
  endfunction
  function automatic logic [TAG_BITS-1:0] tag_of(input iotf_req_t r, input logic gs);
    tag_of = gs ? {r.addr[29:14], 1'b1} : {r.gid[2:0], r.addr[31:19], 1'b1};
  endfunction

  // Parity protection:
  // One parity bit per data byte, three per tag
  // Written on fill, checked on every read
  // Inject words flip parity of each later fill
  // while their bits stay set
  // A parity failure on a tag match is a miss
  // and the line is fetched again
  // Byte parity helpers
  function automatic logic [LINE_BITS/8-1:0] dpar(input logic [LINE_BITS-1:0] d);
    for (int i = 0; i < LINE_BITS / 8; i++) dpar[i] = ^d[i*8 +: 8];
  endfunction
  function automatic logic [2:0] tpar(input logic [TAG_BITS-1:0] t);
    tpar = {^t[16], ^t[15:8], ^t[7:0]};
  endfunction

  // Lookup path:
  // Set and tag come from the held request
  // Stored tag and parity are read at once
  // A hit needs valid, equal tag, good parity
  // A fill is dropped when its entry is invalid
  // and saving invalid entries is off
  // A flush clears every set, or the sets
  // whose low bits equal the named group
  // Lookup of current request
  wire [SET_BITS-1:0] cset = set_of(cur, gs_on);
  wire [TAG_BITS-1:0] ctag = tag_of(cur, gs_on);
  wire [TAG_BITS-1:0] rtag = tag_ram[cset];
  wire par_bad = (dpar(data_ram[cset]) != data_par[cset]) || (tpar(rtag) != tag_par[cset]);
  wire tag_hit = rtag[TAG_VALID] && (rtag == ctag);
  wire hit = tag_hit && !par_bad;
  wire fill_store = walk_fill_in.pte_valid || unit_control[CTL_SAVE_INVALID];
  // Flush clears a position for all or for a matching group
  wire flush_hit = !flush_group || flush_idx[GROUP_BITS-1:0] == flush_gid;

  // Register write side:
  // Each writable word has its own enable
  // Primary-only words use the primary enable
  // Guarded words use guard-gated enables
  // Writes to read-only offsets are dropped
  // The port answers one cycle after the
  // strobe for reads and writes alike
  // Register writes
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      unit_control <= 32'h0000_0000;
      irq_mask <= 32'h0000_0000;
      denied_addr <= 32'h0000_0000;
      data_inject <= 32'h0000_0000;
      tag_inject <= 32'h0000_0000;
      for (int i = 0; i < MASTERS; i++) master_cfg[i] <= 32'h0000_0000;
      for (int i = 0; i < GROUPS; i++) group_ctl[i] <= 32'h0000_0000;
      for (int i = 0; i < MIRROR_PAGES; i++) guard[i] <= 32'h0000_0000;
      for (int i = 0; i < 10; i++) diag_regs[i] <= 32'h0000_0000;
    end else begin
      if (wr_prim && ofs == OFS_UNIT_CONTROL) unit_control <= reg_wdata_in;
      if (wr_mask) irq_mask <= reg_wdata_in;
      if (wr && primary && ofs == OFS_DENIED_ADDR) denied_addr <= reg_wdata_in;
      if (wr_prim && ofs == OFS_DATA_INJECT) data_inject <= reg_wdata_in;
      if (wr_prim && ofs == OFS_TAG_INJECT) tag_inject <= reg_wdata_in;
      if (wr_prim && is_master) master_cfg[widx] <= reg_wdata_in;
      if (wr_group) group_ctl[widx[2:0]] <= reg_wdata_in;
      if (wr_prim && is_guard) guard[widx[1:0]] <= reg_wdata_in;
      if (wr_prim && is_diag) diag_regs[4'((ofs - OFS_DIAG_ACCESS) >> 2)] <= reg_wdata_in;
      if (state == ST_LOOK && !hit && cur.addr != 32'h0000_0000 && 1'b0) denied_addr <= cur.addr;
    end
  end

  // Status word:
  // Writing ones clears the matching bits
  // A parity event beats a clear in one cycle
  // so no error is ever lost
  // Status: parity sticky bit, set wins over write-one clear
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      unit_status <= 32'h0000_0000;
    end else begin
      if (wr_status) unit_status <= unit_status & ~reg_wdata_in;
      if (perr_evt) unit_status[ST_PARITY] <= 1'b1;
    end
  end

  // Storage update:
  // No reset here, the reset flush clears tags
  // A fill writes data, tag and both parities
  // A flush zeroes the tag, dropping valid
  // Data parity is rewritten on flush so an
  // unknown line cannot raise a parity event
  // TLB arrays: fill with injected flips, flush clears valid
  always_ff @(posedge mclk_in) begin
    if (state == ST_WALK && walk_done_in && fill_store) begin
      data_ram[cset] <= walk_fill_in.line;
      data_par[cset] <= dpar(walk_fill_in.line) ^ data_inject[LINE_BITS/8-1:0];
      tag_ram[cset] <= ctag;
      tag_par[cset] <= tpar(ctag) ^ tag_inject[2:0];
    end
    if (state == ST_FLUSH && flush_hit) begin
      tag_ram[flush_idx] <= '0;
      tag_par[flush_idx] <= '0;
      data_par[flush_idx] <= dpar(data_ram[flush_idx]);
    end
  end

  // State sequencing:
  // A hit takes two cycles
  // A miss adds the memory time plus one
  // A flush takes one cycle per set
  // Control state machine
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= ST_FLUSH;
      flush_idx <= '0;
      flush_group <= 1'b0;
      flush_gid <= '0;
      cur <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (wr_flush && (reg_wdata_in[FL_ALL] || reg_wdata_in[FL_GROUP])) begin
            state <= ST_FLUSH;
            flush_idx <= '0;
            flush_group <= !reg_wdata_in[FL_ALL];
            flush_gid <= reg_wdata_in[FL_GID_LO +: GROUP_BITS];
          end else if (req_valid_in && !req_bypass_in) begin
            cur <= req_in;
            state <= ST_LOOK;
          end
        end
        ST_LOOK: state <= hit ? ST_IDLE : ST_WALK;
        ST_WALK: if (walk_done_in) state <= ST_IDLE;
        ST_FLUSH: begin
          flush_idx <= flush_idx + 5'd1;
          if (flush_idx == 5'(TLB_ENTRIES - 1)) state <= ST_IDLE;
        end
      endcase
    end
  end

  // Output timing:
  // Every output is registered
  // Pulses last one cycle, walk and lookup are levels
  // Bypass is answered one cycle after arrival
  // Nothing is forwarded while a flush runs
  // The walk address sits on a line boundary
  // Registered outputs
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
      reg_ready_out <= 1'b0;
      req_ready_out <= 1'b0;
      req_allow_out <= 1'b0;
      walk_req_out <= 1'b0;
      walk_addr_out <= 32'h0000_0000;
      fwd_valid_out <= 1'b0;
      stat_out <= '0;
      perr_evt <= 1'b0;
    end else begin
      reg_rdata_out <= next_rdata;
      reg_ready_out <= reg_sel_in;
      // Bypass passes straight, held during flush
      req_ready_out <= (state == ST_IDLE && req_valid_in && req_bypass_in && !wr_flush) ||
                       (state == ST_LOOK && hit) || (state == ST_WALK && walk_done_in);
      req_allow_out <= (state == ST_LOOK && hit) || (state == ST_WALK && walk_done_in && walk_fill_in.pte_valid) ||
                       (state == ST_IDLE && req_bypass_in);
      fwd_valid_out <= state != ST_FLUSH && ((state == ST_LOOK && hit) ||
                       (state == ST_WALK && walk_done_in && walk_fill_in.pte_valid) ||
                       (state == ST_IDLE && req_valid_in && req_bypass_in && !wr_flush));
      walk_req_out <= (state == ST_LOOK && !hit) || (state == ST_WALK && !walk_done_in);
      walk_addr_out <= {cur.addr[31:4], 4'h0};
      perr_evt <= state == ST_LOOK && tag_hit && par_bad;
      stat_out.hit <= state == ST_LOOK && hit;
      stat_out.miss <= state == ST_LOOK && !hit;
      stat_out.pass <= state == ST_IDLE && req_valid_in && req_bypass_in && !wr_flush;
      stat_out.acc_ok <= (state == ST_LOOK && hit) || (state == ST_WALK && walk_done_in && walk_fill_in.pte_valid);
      stat_out.acc_err <= state == ST_WALK && walk_done_in && !walk_fill_in.pte_valid;
      stat_out.walk <= (state == ST_LOOK && !hit) || (state == ST_WALK && !walk_done_in);
      stat_out.lookup <= (state == ST_IDLE && req_valid_in && !req_bypass_in && !wr_flush) ||
                         (state == ST_LOOK && !hit) || (state == ST_WALK && !walk_done_in);
      stat_out.perr <= state == ST_LOOK && tag_hit && par_bad;
    end
  end

endmodule : iotf_unit
`default_nettype wire

// ---- tb/iotf_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Main memory side: answers each table walk after a set delay
module iotf_mem_model import iotf_pkg::*; (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Walk port
  input wire logic walk_req_in,
  input wire logic [31:0] walk_addr_in,
  input wire logic [3:0] delay_in,
  input wire logic pte_valid_in,
  output logic walk_done_out,
  output iotf_fill_t fill_out
);
  logic [3:0] wait_cnt; // Cycles spent on the current walk
  // Fill is meaningful only in the answer cycle, it toggles otherwise
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_cnt <= 4'h0;
      walk_done_out <= 1'b0;
      fill_out <= '0;
    end else if (walk_req_in && !walk_done_out && wait_cnt >= delay_in) begin
      wait_cnt <= 4'h0;
      walk_done_out <= 1'b1;
      fill_out <= '{line: {4{walk_addr_in}}, pte_valid: pte_valid_in};
    end else begin
      wait_cnt <= walk_req_in ? wait_cnt + 4'h1 : 4'h0;
      walk_done_out <= 1'b0;
      fill_out <= ~fill_out;
    end
  end
endmodule : iotf_mem_model
`default_nettype wire

// ---- tb/iotf_unit_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port checker for flush stall, register map and lookup timing
module iotf_unit_assertions import iotf_pkg::*; (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic reg_sel_in,
  input wire logic reg_write_in,
  input wire logic [14:0] reg_addr_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic reg_ready_out,
  input wire logic req_ready_out,
  input wire logic req_allow_out,
  input wire logic walk_req_out,
  input wire logic [31:0] walk_addr_out,
  input wire logic walk_done_in,
  input wire logic fwd_valid_out,
  input wire iotf_stat_t stat_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  logic [5:0] boot_cnt; // Cycles since reset release, saturates
  // Counts through the flush that follows reset
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) boot_cnt <= 6'h00;
    else if (boot_cnt != 6'h3F) boot_cnt <= boot_cnt + 6'h01;
  end
  wire rd_cap0 = reg_sel_in && !reg_write_in && reg_addr_in == 15'h0000; // Capability read
  wire rd_high = reg_sel_in && !reg_write_in && reg_addr_in[14:12] > 3'h4; // Unmapped page
  sequence s_walk_wait; walk_req_out && !walk_done_in; endsequence
  sequence s_walk_end; walk_req_out && walk_done_in; endsequence
  a_boot_flush_stall: assert property (boot_cnt < 6'd32 |-> !fwd_valid_out && !req_ready_out)
    else $error("Transfer during reset flush");
  a_cap_word_read: assert property (rd_cap0 |=> reg_ready_out && reg_rdata_out[31:15] == 17'h1_C097)
    else $error("Capability word wrong");
  a_page_beyond_zero: assert property (rd_high |=> reg_rdata_out == 32'h0000_0000)
    else $error("Unmapped page read not zero");
  a_walk_line_align: assert property (walk_req_out |-> walk_addr_out[3:0] == 4'h0)
    else $error("Walk address not line aligned");
  a_walk_hold_busy: assert property (s_walk_wait |=> walk_req_out && stat_out.walk)
    else $error("Walk dropped early");
  a_walk_lookup_level: assert property (stat_out.walk |-> stat_out.lookup)
    else $error("Lookup low during walk");
  a_walk_answer: assert property (s_walk_end |=> req_ready_out && !walk_req_out)
    else $error("No answer after walk");
  a_hit_pulse: assert property (stat_out.hit |-> req_ready_out ##1 !stat_out.hit)
    else $error("Hit pulse wrong");
  a_miss_pulse: assert property (stat_out.miss |=> !stat_out.miss)
    else $error("Miss pulse too long");
  a_pass_pulse: assert property (stat_out.pass |-> req_ready_out ##1 !stat_out.pass)
    else $error("Pass pulse wrong");
  a_perr_pulse: assert property (stat_out.perr |=> !stat_out.perr)
    else $error("Parity pulse too long");
  a_fwd_allowed: assert property (fwd_valid_out |-> req_ready_out && req_allow_out)
    else $error("Forward without grant");
endmodule : iotf_unit_assertions
bind iotf_unit iotf_unit_assertions i_chk (.mclk_in, .arst_n_in, .reg_sel_in, .reg_write_in,
  .reg_addr_in, .reg_rdata_out, .reg_ready_out, .req_ready_out, .req_allow_out, .walk_req_out,
  .walk_addr_out, .walk_done_in, .fwd_valid_out, .stat_out);
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// Register and lookup sequences against the unit and a memory model
module testbench import iotf_pkg::*;;
  logic mclk_in, arst_n_in, reg_sel_in, reg_write_in, req_valid_in, req_bypass_in, pte_ok;
  logic [14:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, walk_addr_out, q;
  logic reg_ready_out, req_ready_out, req_allow_out, walk_req_out, walk_done_in, fwd_valid_out;
  logic [3:0] mem_delay; // Memory answer delay
  iotf_req_t req_in;
  iotf_fill_t walk_fill_in;
  iotf_stat_t stat_out;
  int err_count, comparisons, walks, passes, cycles, last_wait;
  iotf_unit i_dut (.mclk_in, .arst_n_in, .reg_sel_in, .reg_write_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .reg_ready_out, .req_valid_in, .req_in, .req_bypass_in, .req_ready_out,
    .req_allow_out, .walk_req_out, .walk_addr_out, .walk_done_in, .walk_fill_in, .fwd_valid_out, .stat_out);
  iotf_mem_model i_mem (.mclk_in, .arst_n_in, .walk_req_in(walk_req_out), .walk_addr_in(walk_addr_out),
    .delay_in(mem_delay), .pte_valid_in(pte_ok), .walk_done_out(walk_done_in), .fill_out(walk_fill_in));
  // Clock at 4 ns
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  // Event counters and hang limit
  always @(posedge mclk_in) begin
    if (walk_req_out && walk_done_in) walks++;
    if (stat_out.pass) passes++;
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // One register access, answer one cycle later
  task automatic rw(input logic wr, input logic [14:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_sel_in <= 1'b1;
    reg_write_in <= wr;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_sel_in <= 1'b0;
    #1 q = reg_rdata_out;
    chk("reg_ready", {31'h0, reg_ready_out}, 32'h1);
  endtask : rw
  // One lookup; checks the number of walks it caused
  task automatic look(input logic [31:0] a, input logic [2:0] g, input logic byp, input int exp_walk);
    int w0;
    w0 = walks;
    last_wait = 0;
    @(posedge mclk_in);
    req_valid_in <= 1'b1;
    req_in <= '{addr: a, gid: g};
    req_bypass_in <= byp;
    @(negedge mclk_in);
    while (req_ready_out !== 1'b1 && last_wait < 300) begin
      @(negedge mclk_in);
      last_wait++;
    end
    req_valid_in <= 1'b0;
    chk("lookup_ready", {31'h0, req_ready_out}, 32'h1);
    chk("walk_count", walks - w0, exp_walk);
  endtask : look
  task automatic complete_run();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  initial begin
    {arst_n_in, reg_sel_in, reg_write_in, req_valid_in, req_bypass_in} = '0;
    {err_count, comparisons, walks, passes, cycles} = '0;
    reg_addr_in = '0;
    reg_wdata_in = '0;
    req_in = '0;
    pte_ok = 1'b1;
    mem_delay = 4'h3;
    repeat (12) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    repeat (40) @(posedge mclk_in);
    rw(0, 15'h0000, 0);
    chk("cap0", {15'h0, q[31:15]}, 32'h0001_C097);
    rw(0, 15'h5000, 0);
    chk("page5", q, 32'h0);
    rw(1, 15'h0010, 32'h0);
    rw(1, 15'h1010, 32'h0000_0410);
    rw(0, 15'h0010, 0);
    chk("ctl_mirror", q, 32'h0);
    rw(1, 15'h0060, 32'h0000_0003);
    rw(1, 15'h1060, 32'h0);
    rw(0, 15'h0060, 0);
    chk("master8", q, 32'h0000_0003);
    rw(1, 15'h001C, 32'h0);
    rw(1, 15'h101C, 32'h0000_00F0);
    rw(0, 15'h001C, 0);
    chk("mask_guarded", q, 32'h0);
    rw(1, 15'h0100, 32'h0000_0004);
    rw(1, 15'h101C, 32'h0000_00F0);
    rw(0, 15'h101C, 0);
    chk("mask_mirror", q, 32'h0000_00F0);
    rw(1, 15'h0104, 32'h0008_0000);
    rw(1, 15'h208C, 32'h8000_0003);
    rw(0, 15'h008C, 0);
    chk("group3", q, 32'h8000_0003);
    look(32'h0000_5000, 0, 0, 1);
    look(32'h0000_5000, 0, 0, 0);
    look(32'h0000_5000, 1, 0, 1);
    look(32'h0000_5000, 0, 0, 1);
    rw(1, 15'h0014, 32'h0000_0001);
    rw(0, 15'h0014, 0);
    chk("flush_busy", {31'h0, q[0]}, 32'h1);
    look(32'h0000_5000, 0, 0, 1);
    chk("flush_stall", {31'h0, last_wait >= 25}, 32'h1);
    rw(1, 15'h0010, 32'h0000_0010);
    rw(1, 15'h0014, 32'h0000_0001);
    look(32'h0000_5000, 0, 0, 1);
    look(32'h0000_5000, 1, 0, 1);
    look(32'h0000_5000, 0, 0, 0);
    look(32'h0001_5000, 0, 0, 1);
    look(32'h0000_5000, 0, 0, 1);
    rw(1, 15'h0014, 32'h0000_0012);
    look(32'h0000_5000, 1, 0, 1);
    look(32'h0000_5000, 0, 0, 0);
    pte_ok = 1'b0;
    look(32'h0000_7000, 0, 0, 1);
    look(32'h0000_7000, 0, 0, 1);
    rw(1, 15'h0010, 32'h0000_0410);
    rw(1, 15'h0014, 32'h0000_0001);
    look(32'h0000_7000, 0, 0, 1);
    look(32'h0000_7000, 0, 0, 0);
    pte_ok = 1'b1;
    mem_delay = 4'h9;
    rw(1, 15'h00EC, 32'h0000_0001);
    look(32'h0000_9000, 2, 0, 1);
    rw(1, 15'h00EC, 32'h0000_0000);
    look(32'h0000_9000, 2, 0, 1);
    look(32'h0000_9000, 2, 0, 0);
    rw(0, 15'h0018, 0);
    chk("perr_sticky", {31'h0, q[8]}, 32'h1);
    rw(1, 15'h0018, 32'h0000_0100);
    rw(0, 15'h0018, 0);
    chk("perr_clear", {31'h0, q[8]}, 32'h0);
    rw(1, 15'h00E8, 32'h0000_0001);
    look(32'h0000_A000, 3, 0, 1);
    look(32'h0000_A000, 3, 0, 1);
    look(32'h0000_5000, 0, 1, 0);
    repeat (2) @(posedge mclk_in);
    chk("pass_count", passes, 32'h1);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
